/* pkg/shsp_pkg.sv */
// constants and types shared by the serial host slave port
package shsp_pkg;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 23;
  localparam int UNIT_BITS = 5;
  localparam logic [4:0] CMD_LAST = 5'h1f;
  localparam logic [4:0] WORD_LAST = 5'h0f;

  // ----------------------------------------------------------------
  // first command word fields
  // ----------------------------------------------------------------
  localparam int CW_DIR_BIT = 15;
  localparam int CW_ALL_BIT = 14;
  localparam int CW_EXT_BIT = 13;
  localparam int CW_STEP_BIT = 12;
  localparam int CW_UNIT_HI = 11;
  localparam int CW_UNIT_LO = 7;
  localparam int CW_ADDR_HI = 6;

  // ----------------------------------------------------------------
  // port control register
  // ----------------------------------------------------------------
  localparam logic [22:0] CTRL_ADDR = 23'h000000;
  localparam int CTRL_BLOCK_BIT = 0;
  localparam int CTRL_TRI_BIT = 1;
  localparam int CTRL_UNIT_LO = 2;
  localparam logic CTRL_BLOCK_RST = 1'h0;
  localparam logic CTRL_TRI_RST = 1'h0;
  localparam logic [4:0] CTRL_UNIT_RST = 5'h00;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ = 2'b11
  } shsp_state_e;

  typedef logic [ADDR_BITS-1:0] shsp_addr_t;
  typedef logic [WORD_BITS-1:0] shsp_word_t;

endpackage

/* hw/shsp_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module shsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock, reset and enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = ce ? d : meta;
    next_q = ce ? meta : q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule // shsp_sync

/* hw/shsp_port.sv */
// serial host slave port: command decode, register access, output path
`timescale 1ns/1ns
module shsp_port (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // register access
  output shsp_pkg::shsp_addr_t reg_addr,
  output shsp_pkg::shsp_word_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire shsp_pkg::shsp_word_t reg_rdata,
  // control state
  output logic passthru_block,
  output logic shared_out_tristate_en,
  output logic [4:0] unit_address
);
  import shsp_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic cs_s, sclk_s, sin_s, cs_d, sclk_d;

  // select resets to deselected so no false falling edge follows reset
  shsp_sync #(.W(3), .RST_VAL(3'b100)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .d({cs_n, sclk, serial_in}),
    .q({cs_s, sclk_s, sin_s})
  );

  logic cs_fall, cs_rise, sclk_rise, sclk_fall;

  assign cs_fall = cs_d & ~cs_s;
  assign cs_rise = ~cs_d & cs_s;
  // shift clock is ignored while deselected
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  shsp_state_e state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [31:0] sh, next_sh;
  shsp_addr_t addr, next_addr;
  logic step, next_step;
  shsp_word_t obuf, next_obuf;
  logic pend, next_pend;
  logic load, next_load;
  shsp_addr_t next_reg_addr;
  shsp_word_t next_reg_wdata;
  logic next_reg_wr, next_reg_rd;
  logic next_block, next_tri;
  logic [4:0] next_unit;
  logic next_sout, next_oe;
  logic next_cs_d, next_sclk_d;

  logic [31:0] shifted;
  logic [15:0] cw1;
  logic hit;
  shsp_word_t ctrl_word;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_addr = addr;
    next_step = step;
    next_obuf = obuf;
    next_pend = pend;
    next_load = 1'b0;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_block = passthru_block;
    next_tri = shared_out_tristate_en;
    next_unit = unit_address;
    // msb first: each new bit enters at the bottom
    shifted = {sh[30:0], sin_s};
    cw1 = shifted[31:16];
    hit = (cw1[CW_UNIT_HI:CW_UNIT_LO] == unit_address);
    ctrl_word = '0;
    ctrl_word[CTRL_BLOCK_BIT] = passthru_block;
    ctrl_word[CTRL_TRI_BIT] = shared_out_tristate_en;
    ctrl_word[CTRL_UNIT_LO +: UNIT_BITS] = unit_address;

    // read data arrives the cycle after the fetch strobe
    if (load) begin
      next_obuf = (addr == CTRL_ADDR) ? ctrl_word : reg_rdata;
      next_pend = 1'b0;
    end

    if (cs_fall) begin
      next_state = ST_CMD;
      next_cnt = '0;
    end else if (cs_rise) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_CMD: begin
          if (sclk_rise) begin
            next_sh = shifted;
            next_cnt = cnt + 5'h01;
            if (cnt == CMD_LAST) begin
              next_cnt = '0;
              next_addr = {cw1[CW_ADDR_HI:0], shifted[15:0]};
              next_step = cw1[CW_STEP_BIT];
              if (cw1[CW_DIR_BIT]) begin
                if (hit) begin
                  next_state = ST_READ;
                  next_reg_rd = 1'b1;
                  next_reg_addr = next_addr;
                end else begin
                  next_state = ST_IDLE;
                end
              end else if (hit || cw1[CW_ALL_BIT]) begin
                next_state = ST_WRITE;
              end else begin
                next_state = ST_IDLE;
              end
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            next_sh = shifted;
            next_cnt = cnt + 5'h01;
            if (cnt == WORD_LAST) begin
              next_cnt = '0;
              if (addr == CTRL_ADDR) begin
                next_block = shifted[CTRL_BLOCK_BIT];
                next_tri = shifted[CTRL_TRI_BIT];
                next_unit = shifted[CTRL_UNIT_LO +: UNIT_BITS];
              end else begin
                next_reg_wr = 1'b1;
                next_reg_addr = addr;
                next_reg_wdata = shifted[15:0];
              end
              if (step) begin
                next_addr = addr + 23'h000001;
              end else begin
                next_state = ST_IDLE;
              end
            end
          end
        end
        ST_READ: begin
          if (sclk_rise) begin
            next_cnt = cnt + 5'h01;
            next_pend = 1'b1;
            if (cnt == WORD_LAST) begin
              next_cnt = '0;
              next_pend = 1'b0;
              if (step) begin
                // refetch at once so the next word needs no gap
                next_addr = addr + 23'h000001;
                next_reg_rd = 1'b1;
                next_reg_addr = next_addr;
              end else begin
                next_state = ST_IDLE;
              end
            end
          end else if (sclk_fall && pend && !load) begin
            next_obuf = {obuf[14:0], 1'b0};
            next_pend = 1'b0;
          end
        end
      endcase
    end
    next_load = reg_rd;

    // output path: read data, else held high or mirrored input
    if (state == ST_READ) begin
      next_sout = obuf[15];
    end else if (passthru_block) begin
      next_sout = 1'b1;
    end else begin
      next_sout = sin_s;
    end
    next_oe = ~(shared_out_tristate_en & cs_s);
    next_cs_d = cs_s;
    next_sclk_d = sclk_s;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      sh <= '0;
      addr <= '0;
      step <= 1'b0;
      obuf <= '0;
      pend <= 1'b0;
      load <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      passthru_block <= CTRL_BLOCK_RST;
      shared_out_tristate_en <= CTRL_TRI_RST;
      unit_address <= CTRL_UNIT_RST;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b1;
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      addr <= next_addr;
      step <= next_step;
      obuf <= next_obuf;
      pend <= next_pend;
      load <= next_load;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
      passthru_block <= next_block;
      shared_out_tristate_en <= next_tri;
      unit_address <= next_unit;
      serial_out <= next_sout;
      serial_out_oe <= next_oe;
      cs_d <= next_cs_d;
      sclk_d <= next_sclk_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cs_restart;
    @(posedge mclk) disable iff (rst)
      ce && cs_fall |=> state == ST_CMD && cnt == 5'h00;
  endproperty
  a_cs_restart: assert property (p_cs_restart) else $error("no restart on select");
  property p_cs_end;
    @(posedge mclk) disable iff (rst)
      ce && cs_rise && !cs_fall |=> state == ST_IDLE;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("transaction not ended");
  property p_idle_hold;
    @(posedge mclk) disable iff (rst)
      ce && state == ST_IDLE && !cs_fall |=> state == ST_IDLE && $stable(sh);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle port moved");
  property p_mirror;
    @(posedge mclk) disable iff (rst)
      ce && !passthru_block && state != ST_READ |=> serial_out == $past(sin_s);
  endproperty
  a_mirror: assert property (p_mirror) else $error("input not mirrored");
  property p_block_high;
    @(posedge mclk) disable iff (rst)
      ce && passthru_block && state != ST_READ |=> serial_out;
  endproperty
  a_block_high: assert property (p_block_high) else $error("blocked output not high");
  property p_tristate;
    @(posedge mclk) disable iff (rst)
      ce && shared_out_tristate_en && cs_s |=> !serial_out_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("output driven while deselected");
  property p_unit_miss;
    @(posedge mclk) disable iff (rst)
      ce && state == ST_CMD && !cs_fall && !cs_rise && sclk_rise && cnt == CMD_LAST
      && !hit && (cw1[CW_DIR_BIT] || !cw1[CW_ALL_BIT]) |=> state == ST_IDLE && !reg_rd;
  endproperty
  a_unit_miss: assert property (p_unit_miss) else $error("foreign unit accepted");
  property p_write_out;
    @(posedge mclk) disable iff (rst)
      ce && state == ST_WRITE && !cs_fall && !cs_rise && sclk_rise && cnt == WORD_LAST
      && addr != CTRL_ADDR |=> reg_wr && reg_addr == $past(addr) ##1 !reg_wr;
  endproperty
  a_write_out: assert property (p_write_out) else $error("write strobe wrong");
  property p_step;
    @(posedge mclk) disable iff (rst)
      ce && state == ST_WRITE && step && !cs_fall && !cs_rise && sclk_rise
      && cnt == WORD_LAST |=> addr == $past(addr) + 23'h000001;
  endproperty
  a_step: assert property (p_step) else $error("address not stepped");
  property p_launch;
    @(posedge mclk) disable iff (rst)
      ce && state == ST_READ && !cs_fall && !cs_rise && sclk_fall && pend && !load
      |=> obuf == {$past(obuf[14:0]), 1'b0} ##1 serial_out == obuf[15] || !ce;
  endproperty
  a_launch: assert property (p_launch) else $error("read bit not launched on fall");

endmodule // shsp_port

/* testbench/shsp_host_model.sv */
// host processor model driving the serial pins
`timescale 1ns/1ns
module shsp_host_model (
  // clock
  input wire logic mclk,
  // serial pins
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic cs_n,
  output logic sclk,
  output logic serial_in
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // pin timing, half a shift-clock period is ten system clocks
  // ----------------------------------------------------------------
  task automatic hc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic sel(input logic v);
    cs_n <= v;
    hc(10);
  endtask

  task automatic bits(input logic [15:0] w, input int nb, output logic [15:0] rx);
    rx = '0;
    for (int i = 0; i < nb; i++) begin
      serial_in <= w[15-i];
      hc(10);
      sclk <= 1'b1;
      // an undriven shared line reads as the inverse of the current serial_out value
      rx = {rx[14:0], serial_out_oe ? serial_out : ~serial_out};
      hc(10);
      sclk <= 1'b0;
    end
  endtask

  task automatic gap();
    hc(80);
  endtask

  // deselect, invert the data line, then inter-command spacing
  task automatic close();
    hc(10);
    sel(1'b1);
    serial_in <= ~serial_in;
    hc(70);
  endtask
endmodule // shsp_host_model

/* testbench/serial_host_slave_port_tb.sv */
// self-checking bench for the serial host slave port
`timescale 1ns/1ns
module serial_host_slave_port_tb;
  import shsp_pkg::*;
  logic mclk, rst, ce, cs_n, sclk, serial_in, serial_out, serial_out_oe;
  logic reg_wr, reg_rd, passthru_block, shared_out_tristate_en;
  logic [4:0] unit_address;
  logic [31:0] seed, r;
  shsp_addr_t reg_addr, a;
  shsp_word_t reg_wdata, reg_rdata, rx;
  shsp_addr_t wa[$];
  shsp_word_t wd[$];
  shsp_word_t dw[4], rd[4];
  int n_mismatch, n_tests, cyc;

  shsp_port DUT (.mclk, .rst, .ce, .cs_n, .sclk, .serial_in, .serial_out, .serial_out_oe,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .passthru_block,
    .shared_out_tristate_en, .unit_address);
  shsp_host_model host (.mclk, .serial_out, .serial_out_oe, .cs_n, .sclk, .serial_in);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic shsp_word_t rm(input shsp_addr_t x);
    return x[15:0] ^ 16'h5a3c;
  endfunction

  function automatic shsp_word_t cw1(input logic d, b, s, input logic [4:0] u,
      input shsp_addr_t x);
    return {d, b, 1'b1, s, u, x[22:16]};
  endfunction

  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one framed access; ne is the number of accepted words
  task automatic xfer(input logic d, b, s, input logic [4:0] u, input shsp_addr_t x,
      input int n, ne);
    wa.delete();
    wd.delete();
    host.sel(1'b0);
    host.bits(cw1(d, b, s, u, x), 16, rx);
    host.bits(x[15:0], 16, rx);
    if (d) host.gap();
    for (int i = 0; i < n; i++) host.bits(dw[i], 16, rd[i]);
    host.close();
    if (!d) chk(wa.size(), ne);
    if (d && ne == 0) chk(rd[0], dw[0]);
    for (int i = 0; i < ne; i++) begin
      if (d) begin
        chk(rd[i], rm(x + 23'(i)));
      end else begin
        chk(wa[i], x + 23'(i));
        chk(wd[i], dw[i]);
      end
    end
  endtask

  task automatic mirror(input logic v, e);
    host.serial_in <= v;
    host.hc(8);
    chk(serial_out, e);
  endtask

  // ----------------------------------------------------------------
  // register side and watchdog
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (reg_wr === 1'b1) begin
      wa.push_back(reg_addr);
      wd.push_back(reg_wdata);
    end
    if (reg_rd === 1'b1) reg_rdata <= rm(reg_addr);
    if (cyc == 90000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_rdata = '0;
    seed = 32'h340f423b;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    host.hc(4);
    chk({passthru_block, shared_out_tristate_en, unit_address, serial_out_oe}, 8'h01);
    mirror(1'b1, 1'b1);
    mirror(1'b0, 1'b0);
    ce <= 1'b0;
    mirror(1'b1, 1'b0);
    ce <= 1'b1;
    host.hc(8);
    chk(serial_out, 1'b1);
    host.bits(16'ha5a5, 16, rx);
    chk(wa.size(), 0);
    for (int k = 0; k < 6; k++) begin
      r = xs();
      a = (r[22:0] & 23'h7ffff0) | 23'h10;
      dw[0] = r[31:16];
      xfer(1'b0, r[5], 1'b0, 5'h00, a, 1, 1);
    end
    for (int i = 0; i < 3; i++) dw[i] = shsp_word_t'(xs());
    xfer(1'b0, 1'b0, 1'b1, 5'h00, a, 3, 3);
    xfer(1'b1, 1'b0, 1'b0, 5'h00, a, 1, 1);
    xfer(1'b1, 1'b0, 1'b1, 5'h00, a, 3, 3);
    dw[0] = 16'h0014;
    xfer(1'b0, 1'b0, 1'b0, 5'h00, '0, 1, 0);
    chk(unit_address, 5'h05);
    dw[0] = shsp_word_t'(xs());
    xfer(1'b0, 1'b0, 1'b0, 5'h00, a, 1, 0);
    xfer(1'b0, 1'b1, 1'b0, 5'h00, a, 1, 1);
    xfer(1'b1, 1'b0, 1'b0, 5'h05, a, 1, 1);
    xfer(1'b1, 1'b1, 1'b0, 5'h00, a, 1, 0);
    dw[0] = 16'h0015;
    xfer(1'b0, 1'b0, 1'b0, 5'h05, '0, 1, 0);
    chk(passthru_block, 1'b1);
    mirror(1'b0, 1'b1);
    dw[0] = 16'h0016;
    xfer(1'b0, 1'b0, 1'b0, 5'h05, '0, 1, 0);
    chk(serial_out_oe, 1'b0);
    mirror(1'b1, 1'b1);
    mirror(1'b0, 1'b0);
    host.sel(1'b0);
    chk(serial_out_oe, 1'b1);
    host.bits(16'hffff, 9, rx);
    host.close();
    dw[0] = shsp_word_t'(xs());
    xfer(1'b0, 1'b0, 1'b0, 5'h05, a, 1, 1);
    rst <= 1'b1;
    host.hc(4);
    rst <= 1'b0;
    host.hc(4);
    chk({passthru_block, shared_out_tristate_en, unit_address, serial_out_oe}, 8'h01);
    xfer(1'b0, 1'b0, 1'b0, 5'h00, a, 1, 1);
    end_of_test();
  end
endmodule // serial_host_slave_port_tb
